// ### pmd_bcd_conv.sv
`timescale 1ns/1ps
// ===================================================
// shift-and-add-three converter, one bit per clock
module pmd_bcd_conv
  import pmd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // request and result
  pmd_conv_if.conv cv
);
  typedef struct packed {
    logic        busy;
    logic [5:0]  cnt;
    logic [31:0] bin;
    logic [39:0] work;
    logic [39:0] bcd;
    logic        done;
  } pmd_conv_state_t;

  pmd_conv_state_t s;
  pmd_conv_state_t next_s;
  logic [39:0]     adj;

  // digits of five or more get three added before the shift
  genvar i;
  for (i = 0; i < 10; i++) begin : g_adj
    assign adj[i*4 +: 4] = (s.work[i*4 +: 4] >= 4'h5) ? s.work[i*4 +: 4] + 4'h3 : s.work[i*4 +: 4];
  end

  // one conversion at a time; a start while busy is ignored
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (!s.busy) begin
      if (cv.start) begin
        next_s.busy = 1'b1;
        next_s.cnt  = 6'h00;
        next_s.bin  = cv.magnitude;
        next_s.work = 40'h0;
      end
    end else begin
      next_s.work = {adj[38:0], s.bin[31]};
      next_s.bin  = {s.bin[30:0], 1'b0};
      if (s.cnt == CONV_STEPS - 6'h01) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.bcd  = {adj[38:0], s.bin[31]};
      end else begin
        next_s.cnt = s.cnt + 6'h01;
      end
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cv.done = s.done;
  assign cv.bcd  = s.bcd;

  // ===================================================
  // checks
  a_conv_latency: assert property (@(posedge clock) disable iff (reset)
    cv.start && !s.busy |-> ##33 cv.done) else $error("conversion did not finish in 33 cycles");
endmodule

// ### pmd_conv_if.sv
`timescale 1ns/1ps
// ===================================================
// binary to decimal converter hand-off
interface pmd_conv_if;
  logic        start;
  logic [31:0] magnitude;
  logic        done;
  logic [39:0] bcd;
  modport conv (input start, input magnitude, output done, output bcd);
  modport user (output start, output magnitude, input done, input bcd);
endinterface

// ### pmd_front_keys.sv
`timescale 1ns/1ps
// ===================================================
// front panel keys, levels held for whole cycles
module pmd_front_keys (
  // clock
  input  wire logic clock,
  // keys, high while pressed
  output logic      mode_key,
  output logic      up_key,
  output logic      down_key,
  output logic      shift_key
);
  logic [3:0] held = 4'h0;
  assign {shift_key, down_key, up_key, mode_key} = held;
  // gap after release so the next press is a fresh edge
  task automatic push(input int k, input int n);
    @(posedge clock);
    held[k] <= 1'b1;
    repeat (n) @(posedge clock);
    held[k] <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
endmodule

// ### pmd_panel.sv
`timescale 1ns/1ps
// Contract
// - mode/set press opens the monitor selection screen
// - up and down keys step the selected monitor number
// - long data/shift hold on a 32-bit monitor shows lower four digits
// - data/shift press on lower group shows middle four digits
// - data/shift press on middle group shows upper two digits
// - data/shift press on upper group returns to lower four digits
// - long data/shift hold on a value returns to selection screen
// - count shown as signed decimal over the full 32-bit range
// - decrement below most negative wraps to most positive
// - increment above most positive wraps to most negative
// - input monitor shows present state of the eight inputs
// - input off lights the top segment of its position
// - input on lights the bottom segment of its position
// - input positions one to eight follow the factory allocation
// - open contact is off, shorted contact is on
// - output monitor shows present state of the eight outputs; speed match shows in position two only with CTRL_SPEED set
// - output off lights the top segment of its position
// - output on lights the bottom segment of its position
// - output positions one to seven follow allocation, eight reserved
// - transistor off reads off, conducting reads on
module pmd_panel
  import pmd_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = HOLD_TIME_MS * CLK_KHZ
)(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // front panel keys, high while pressed
  input  wire logic        mode_key,
  input  wire logic        up_key,
  input  wire logic        down_key,
  input  wire logic        shift_key,
  // feedback pulses, one per count
  input  wire logic        feedback_pulse_up,
  input  wire logic        feedback_pulse_down,
  // input signals, high when the contact is shorted
  input  wire logic        servo_on_input,
  input  wire logic        proportional_control_input,
  input  wire logic        forward_overtravel_input,
  input  wire logic        reverse_overtravel_input,
  input  wire logic        fault_clear_input,
  input  wire logic        forward_current_limit_input,
  input  wire logic        reverse_current_limit_input,
  input  wire logic        encoder_data_request_input,
  // output signals, high while the transistor conducts
  input  wire logic        fault_output,
  input  wire logic        positioning_done_output,
  input  wire logic        speed_match_output,
  input  wire logic        rotation_detect_output,
  input  wire logic        servo_ready_output,
  input  wire logic        fault_code_bit1_output,
  input  wire logic        fault_code_bit2_output,
  input  wire logic        fault_code_bit3_output,
  // five characters, char 0 rightmost, bits a..g, dp
  output logic      [39:0] seg_out,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  typedef struct packed {
    pmd_panel_t  panel;
    pmd_group_t  group;
    pmd_mon_t    mon;
    logic [27:0] hold_cnt;
    logic        hold_fired;
    logic        shift_prev;
    logic        mode_prev;
    logic        up_prev;
    logic        down_prev;
    logic [31:0] count;
    logic        conv_start;
    logic        conv_busy;
    logic        conv_neg;
    logic [31:0] conv_mag;
    logic [39:0] bcd;
    logic        neg;
    logic [2:0]  ctrl;
    logic [39:0] seg;
    logic        aw_held;
    logic [7:0]  awaddr;
    logic        w_held;
    logic [31:0] wdata;
    logic        wstrb0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pmd_top_state_t;

  pmd_top_state_t s;
  pmd_top_state_t next_s;
  logic           mode_press;
  logic           up_press;
  logic           down_press;
  logic           short_ev;
  logic           long_ev;
  logic [7:0]     in_state;
  logic [7:0]     out_state;
  logic [39:0]    disp;
  pmd_conv_if     cv();

  // ===================================================
  // helpers
  function automatic pmd_reg_t reg_sel(input logic [7:0] addr);
    if (addr == OFS_CTRL) begin
      return REG_CTRL;
    end else if (addr == OFS_STATUS) begin
      return REG_STATUS;
    end else if (addr == OFS_COUNT) begin
      return REG_COUNT;
    end else if (addr == OFS_SIGS) begin
      return REG_SIGS;
    end else begin
      return REG_NONE;
    end
  endfunction

  function automatic logic [7:0] seg_hex(input logic [3:0] v);
    case (v)
      4'h0: return 8'h3F;
      4'h1: return 8'h06;
      4'h2: return 8'h5B;
      4'h3: return 8'h4F;
      4'h4: return 8'h66;
      4'h5: return 8'h6D;
      4'h6: return 8'h7D;
      4'h7: return 8'h07;
      4'h8: return 8'h7F;
      4'h9: return 8'h6F;
      4'hA: return 8'h77;
      4'hB: return 8'h7C;
      4'hC: return 8'h39;
      4'hD: return 8'h5E;
      4'hE: return 8'h79;
      default: return 8'h71;
    endcase
  endfunction

  // position p+1 sits in char p/2: odd positions right half, even left
  function automatic logic [39:0] sig_segs(input logic [7:0] on);
    logic [39:0] r;
    r = '0;
    for (int p = 0; p < 8; p++) begin
      if (p % 2 == 0) begin
        r[(p / 2) * 8 + (on[p] ? SEG_C : SEG_B)] = 1'b1;
      end else begin
        r[(p / 2) * 8 + (on[p] ? SEG_E : SEG_F)] = 1'b1;
      end
    end
    return r;
  endfunction

  // ===================================================
  // signal gathering; a high pin is the on state
  assign in_state  = {encoder_data_request_input, reverse_current_limit_input,
                      forward_current_limit_input, fault_clear_input, reverse_overtravel_input,
                      forward_overtravel_input, proportional_control_input, servo_on_input};
  assign out_state = {1'b0, fault_code_bit3_output, fault_code_bit2_output,
                      fault_code_bit1_output, servo_ready_output, rotation_detect_output,
                      s.ctrl[CTRL_SPEED] ? speed_match_output : positioning_done_output,
                      fault_output};

  // key edges; keys arrive synchronous to the clock
  assign mode_press = mode_key && !s.mode_prev;
  assign up_press   = up_key && !s.up_prev;
  assign down_press = down_key && !s.down_prev;

  // display image built from present state, registered below
  always_comb begin
    disp = {5{GLYPH_BLANK}};
    if (s.ctrl[CTRL_EN]) begin
      case (s.panel)
        PANEL_SELECT: begin
          disp = {GLYPH_U, GLYPH_N, seg_hex(4'h0), seg_hex(4'h0), seg_hex(4'h0)};
          case (s.mon)
            MON_INPUT:  disp[23:0] = {seg_hex(MON_CODE_IN[11:8]), seg_hex(MON_CODE_IN[7:4]),
                                      seg_hex(MON_CODE_IN[3:0])};
            MON_OUTPUT: disp[23:0] = {seg_hex(MON_CODE_OUT[11:8]), seg_hex(MON_CODE_OUT[7:4]),
                                      seg_hex(MON_CODE_OUT[3:0])};
            default:    disp[23:0] = {seg_hex(MON_CODE_CNT[11:8]), seg_hex(MON_CODE_CNT[7:4]),
                                      seg_hex(MON_CODE_CNT[3:0])};
          endcase
        end
        PANEL_VALUE: begin
          case (s.mon)
            MON_INPUT:  disp = sig_segs(in_state);
            MON_OUTPUT: disp = sig_segs(out_state);
            default: begin
              case (s.group)
                GROUP_LOWER:  disp[31:0] = {seg_hex(s.bcd[15:12]), seg_hex(s.bcd[11:8]),
                                            seg_hex(s.bcd[7:4]), seg_hex(s.bcd[3:0])};
                GROUP_MIDDLE: disp[31:0] = {seg_hex(s.bcd[31:28]), seg_hex(s.bcd[27:24]),
                                            seg_hex(s.bcd[23:20]), seg_hex(s.bcd[19:16])};
                default:      disp = {s.neg ? GLYPH_MINUS : GLYPH_BLANK, GLYPH_BLANK,
                                      GLYPH_BLANK, seg_hex(s.bcd[39:36]), seg_hex(s.bcd[35:32])};
              endcase
            end
          endcase
        end
        default: disp = {5{GLYPH_BLANK}};
      endcase
    end
  end

  // ===================================================
  // next state
  always_comb begin
    next_s = s;
    short_ev = 1'b0;
    long_ev = 1'b0;
    next_s.mode_prev  = mode_key;
    next_s.up_prev    = up_key;
    next_s.down_prev  = down_key;
    next_s.shift_prev = shift_key;
    next_s.seg        = disp;
    next_s.conv_start = 1'b0;

    // long hold fires once per press; release before it is a short press
    if (shift_key) begin
      if (!s.hold_fired) begin
        if (s.hold_cnt == 28'(HOLD_CYCLES - 1)) begin
          long_ev = 1'b1;
          next_s.hold_fired = 1'b1;
        end else begin
          next_s.hold_cnt = s.hold_cnt + 28'h1;
        end
      end
    end else begin
      short_ev = s.shift_prev && !s.hold_fired;
      next_s.hold_cnt = 28'h0;
      next_s.hold_fired = 1'b0;
    end

    // panel sequence; mode key wins over every other key
    if (mode_press) begin
      next_s.panel = PANEL_SELECT;
    end else begin
      case (s.panel)
        PANEL_SELECT: begin
          if (long_ev) begin
            next_s.panel = PANEL_VALUE;
            next_s.group = GROUP_LOWER;
          end else if (up_press && !down_press) begin
            next_s.mon = (s.mon == MON_COUNT) ? MON_INPUT : pmd_mon_t'(s.mon + 2'h1);
          end else if (down_press && !up_press) begin
            next_s.mon = (s.mon == MON_INPUT) ? MON_COUNT : pmd_mon_t'(s.mon - 2'h1);
          end
        end
        PANEL_VALUE: begin
          if (long_ev) begin
            next_s.panel = PANEL_SELECT;
          end else if (short_ev && s.mon == MON_COUNT) begin
            case (s.group)
              GROUP_LOWER:  next_s.group = GROUP_MIDDLE;
              GROUP_MIDDLE: next_s.group = GROUP_UPPER;
              default:      next_s.group = GROUP_LOWER;
            endcase
          end
        end
        default: next_s.panel = PANEL_STATUS;
      endcase
    end

    // counter wraps at the 32-bit signed limits by plain two's complement
    if (feedback_pulse_up && !feedback_pulse_down) begin
      next_s.count = s.count + 32'h1;
    end else if (feedback_pulse_down && !feedback_pulse_up) begin
      next_s.count = s.count - 32'h1;
    end

    // restart conversion as soon as the last one lands, so the shown value tracks the count
    if (cv.done) begin
      next_s.bcd = cv.bcd;
      next_s.neg = s.conv_neg;
      next_s.conv_busy = 1'b0;
    end else if (!s.conv_busy) begin
      next_s.conv_start = 1'b1;
      next_s.conv_busy = 1'b1;
      next_s.conv_neg = s.count[31];
      next_s.conv_mag = s.count[31] ? ~s.count + 32'h1 : s.count;
    end

    // write channel: address and data taken in either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb0 = s_axi_wstrb[0];
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = RESP_OKAY;
      case (reg_sel(s.awaddr))
        REG_CTRL: begin
          if (s.wstrb0) begin
            next_s.ctrl = s.wdata[2:0] & 3'h5;
            if (s.wdata[CTRL_CLR]) begin
              next_s.count = 32'h0; // clear beats a same-cycle pulse
            end
          end
        end
        REG_NONE: next_s.bresp = RESP_DEC;
        default:  next_s.bresp = RESP_OKAY;
      endcase
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready  = !next_s.w_held && !next_s.bvalid;

    // read channel: one read in flight
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      next_s.rdata  = 32'h0;
      case (reg_sel(s_axi_araddr))
        REG_CTRL:   next_s.rdata[2:0] = s.ctrl;
        REG_STATUS: begin
          next_s.rdata[STAT_PANEL +: 2] = s.panel;
          next_s.rdata[STAT_GROUP +: 2] = s.group;
          next_s.rdata[STAT_MON +: 2]   = s.mon;
          next_s.rdata[STAT_NEG]        = s.count[31];
        end
        REG_COUNT:  next_s.rdata = s.count;
        REG_SIGS:   next_s.rdata[15:0] = {out_state, in_state};
        default:    next_s.rresp = RESP_DEC;
      endcase
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    next_s.arready = !next_s.rvalid;
  end

  // state register
  always_ff @(posedge clock) begin
    if (reset) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ===================================================
  // converter and outputs
  assign cv.start     = s.conv_start;
  assign cv.magnitude = s.conv_mag;

  pmd_bcd_conv u_conv (
    .clock (clock),
    .reset (reset),
    .cv    (cv.conv)
  );

  assign seg_out       = s.seg;
  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;

  // ===================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_mode_enter: assert property (mode_press |=> s.panel == PANEL_SELECT)
    else $error("mode key did not open selection");
  a_mon_step: assert property (s.panel == PANEL_SELECT && s.mon == MON_INPUT && up_press
    && !down_press && !mode_press && !long_ev |=> s.mon == MON_OUTPUT) else $error("up key did not step");
  a_long_enter: assert property (s.panel == PANEL_SELECT && long_ev && !mode_press
    |=> s.panel == PANEL_VALUE && s.group == GROUP_LOWER) else $error("hold did not show lower group");
  a_step_middle: assert property (s.panel == PANEL_VALUE && s.mon == MON_COUNT && short_ev
    && s.group == GROUP_LOWER && !mode_press |=> s.group == GROUP_MIDDLE) else $error("no middle group");
  a_step_upper: assert property (s.panel == PANEL_VALUE && s.mon == MON_COUNT && short_ev
    && s.group == GROUP_MIDDLE && !mode_press |=> s.group == GROUP_UPPER) else $error("no upper group");
  a_group_rotate: assert property (s.panel == PANEL_VALUE && s.mon == MON_COUNT && short_ev
    && s.group == GROUP_UPPER && !mode_press |=> s.group == GROUP_LOWER) else $error("groups did not rotate");
  a_long_return: assert property (s.panel == PANEL_VALUE && long_ev && !mode_press
    |=> s.panel == PANEL_SELECT) else $error("hold did not return to selection");
  a_wrap_down: assert property (s.count == 32'h8000_0000 && feedback_pulse_down && !feedback_pulse_up
    && !(s.aw_held && s.w_held) |=> s.count == 32'h7FFF_FFFF) else $error("no wrap to most positive");
  a_wrap_up: assert property (s.count == 32'h7FFF_FFFF && feedback_pulse_up && !feedback_pulse_down
    && !(s.aw_held && s.w_held) |=> s.count == 32'h8000_0000) else $error("no wrap to most negative");
  a_input_top: assert property (s.panel == PANEL_VALUE && s.mon == MON_INPUT && s.ctrl[CTRL_EN]
    |=> s.seg[SEG_B] == !$past(servo_on_input)) else $error("off input top segment wrong");
  a_input_bottom: assert property (s.panel == PANEL_VALUE && s.mon == MON_INPUT && s.ctrl[CTRL_EN]
    |=> s.seg[SEG_C] == $past(servo_on_input)) else $error("on input bottom segment wrong");
  a_output_segs: assert property (s.panel == PANEL_VALUE && s.mon == MON_OUTPUT && s.ctrl[CTRL_EN]
    |=> s.seg[SEG_C] == $past(fault_output) && s.seg[SEG_B] == !$past(fault_output))
    else $error("output segments wrong");

  c_group_rotate: cover property (s.group == GROUP_UPPER ##1 s.group == GROUP_LOWER);
  c_wrap_up: cover property (s.count == 32'h7FFF_FFFF ##1 s.count == 32'h8000_0000);
  c_input_shown: cover property (s.panel == PANEL_VALUE && s.mon == MON_INPUT);
  c_bus_write: cover property (s.bvalid && s_axi_bready);
endmodule

// ### pmd_pkg.sv
package pmd_pkg;
  // ===================================================
  // register map (byte addresses)
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_STATUS = 8'h04;
  localparam logic [7:0]  OFS_COUNT  = 8'h08;
  localparam logic [7:0]  OFS_SIGS   = 8'h0C;
  // control fields
  localparam int          CTRL_EN    = 0;
  localparam int          CTRL_CLR   = 1;
  localparam int          CTRL_SPEED = 2;
  localparam logic [2:0]  CTRL_RESET = 3'h1;
  // status fields
  localparam int          STAT_PANEL = 0;
  localparam int          STAT_GROUP = 2;
  localparam int          STAT_MON   = 4;
  localparam int          STAT_NEG   = 8;
  // bus answers
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_DEC   = 2'h3;
  // ===================================================
  // timing
  localparam int unsigned HOLD_TIME_MS = 1000;
  localparam int unsigned CLK_KHZ      = 250000;
  localparam logic [5:0]  CONV_STEPS   = 6'h20;
  // ===================================================
  // monitor numbers shown on the selection screen
  localparam logic [11:0] MON_CODE_IN  = 12'h005;
  localparam logic [11:0] MON_CODE_OUT = 12'h006;
  localparam logic [11:0] MON_CODE_CNT = 12'h00D;
  // segment bits and glyphs, bit set means lit
  localparam int          SEG_B = 1;
  localparam int          SEG_C = 2;
  localparam int          SEG_E = 4;
  localparam int          SEG_F = 5;
  localparam logic [7:0]  GLYPH_U     = 8'h3E;
  localparam logic [7:0]  GLYPH_N     = 8'h54;
  localparam logic [7:0]  GLYPH_MINUS = 8'h40;
  localparam logic [7:0]  GLYPH_BLANK = 8'h00;
  // ===================================================
  // types
  typedef enum logic [1:0] {PANEL_STATUS, PANEL_SELECT, PANEL_VALUE} pmd_panel_t;
  typedef enum logic [1:0] {GROUP_LOWER, GROUP_MIDDLE, GROUP_UPPER} pmd_group_t;
  typedef enum logic [1:0] {MON_INPUT, MON_OUTPUT, MON_COUNT} pmd_mon_t;
  typedef enum logic [2:0] {REG_CTRL, REG_STATUS, REG_COUNT, REG_SIGS, REG_NONE} pmd_reg_t;
endpackage

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  import pmd_pkg::*;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        pu = 1'b0, pd = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [7:0]  ins = 8'h00, outs = 8'h00, aw = 8'h00, ar = 8'h00;
  logic [31:0] wd = 32'h0, rd, got;
  logic        mk, uk, dk, sk, awr, wr, bv, arr, rv;
  logic [1:0]  br, rr;
  logic [39:0] seg;
  int          errors = 0, checks = 0;
  always #2 clock = ~clock;
  pmd_front_keys u_keys (.clock(clock), .mode_key(mk), .up_key(uk), .down_key(dk), .shift_key(sk));
  pmd_panel #(.HOLD_CYCLES(8)) u_dut (.clock(clock), .reset(reset), .mode_key(mk), .up_key(uk), .down_key(dk),
    .shift_key(sk), .feedback_pulse_up(pu), .feedback_pulse_down(pd), .servo_on_input(ins[0]),
    .proportional_control_input(ins[1]), .forward_overtravel_input(ins[2]), .reverse_overtravel_input(ins[3]),
    .fault_clear_input(ins[4]), .forward_current_limit_input(ins[5]), .reverse_current_limit_input(ins[6]),
    .encoder_data_request_input(ins[7]), .fault_output(outs[0]), .positioning_done_output(outs[1]),
    .speed_match_output(outs[2]), .rotation_detect_output(outs[3]), .servo_ready_output(outs[4]),
    .fault_code_bit1_output(outs[5]), .fault_code_bit2_output(outs[6]), .fault_code_bit3_output(outs[7]),
    .seg_out(seg), .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre));
  // ===================================================
  // shared tasks
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    aw  <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clock);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!bv);
    bre <= 1'b0;
    chk(br, RESP_OKAY);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    // rready stays high between reads, so back-to-back reads never assign it twice in one step
    ar  <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clock);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    d = rd;
    r = rr;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [1:0] r;
    rd_reg(a, got, r);
    chk(got, e);
    chk(r, RESP_OKAY);
  endtask
  // off lights top, on lights bottom; odd position right half, even left
  function automatic logic [31:0] sig_glyphs(input logic [7:0] v);
    sig_glyphs = 32'h0;
    for (int p = 0; p < 8; p++) sig_glyphs[8*(p/2) + ((p%2) ? (v[p] ? SEG_E : SEG_F) : (v[p] ? SEG_C : SEG_B))] = 1'b1;
  endfunction
  // ===================================================
  // scenarios
  task automatic t_signals;
    logic [1:0] r;
    rd_chk(OFS_CTRL, 32'h1);
    rd_reg(8'h10, got, r);
    chk(r, RESP_DEC);
    u_keys.push(0, 2);
    rd_chk(OFS_STATUS, 32'h1);
    ins <= 8'hA5;
    u_keys.push(3, 10);
    rd_chk(OFS_STATUS, 32'h2);
    chk(seg, 40'h00_1212_2424);
    ins <= 8'h5A;
    repeat (4) @(posedge clock);
    chk(seg[31:0], sig_glyphs(8'h5A));
    u_keys.push(3, 10);
    rd_chk(OFS_STATUS, 32'h1);
    u_keys.push(1, 2);
    rd_chk(OFS_STATUS, 32'h11);
    outs <= 8'hC3;
    u_keys.push(3, 10);
    chk(seg[31:0], sig_glyphs(8'h63));
    wr_reg(OFS_CTRL, 32'h5);
    repeat (2) @(posedge clock);
    chk(seg[31:0], sig_glyphs(8'h61));
    u_keys.push(3, 10);
  endtask
  task automatic t_count;
    for (int i = 0; i < 7; i++) begin
      @(posedge clock);
      pd <= (i < 5);
      pu <= (i >= 5);
      @(posedge clock);
      pd <= 1'b0;
      pu <= 1'b0;
    end
    rd_chk(OFS_COUNT, 32'hFFFFFFFD);
    u_keys.push(2, 2);
    rd_chk(OFS_STATUS, 32'h101);
    u_keys.push(2, 2);
    rd_chk(OFS_STATUS, 32'h121);
    u_keys.push(3, 10);
    rd_chk(OFS_STATUS, 32'h122);
    u_keys.push(3, 2);
    rd_chk(OFS_STATUS, 32'h126);
    u_keys.push(3, 2);
    rd_chk(OFS_STATUS, 32'h12A);
    repeat (40) @(posedge clock);
    chk(seg, {GLYPH_MINUS, 32'h0000_3F3F});
    u_keys.push(3, 2);
    rd_chk(OFS_STATUS, 32'h122);
    chk(seg, 40'h00_3F3F_3F4F);
    wr_reg(OFS_CTRL, 32'h3);
    rd_chk(OFS_COUNT, 32'h0);
  endtask
  task complete_run;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // main sequence after five reset cycles
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    t_signals;
    t_count;
    complete_run;
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    complete_run;
  end
endmodule
